// ### rtl/rsw_pkg.sv
// Purpose: Shared constants for the reset source and watchdog block.
// Assumes: 10 MHz system clock, 32-bit AHB-Lite register port.
// Notes:   Every offset and every field position but the comparator select bit 0 is here; start-up counts and most register reset values live in the modules.
package rsw_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFS_CAUSE = 8'h00;
    localparam logic [7:0] OFS_DOGCTL = 8'h04;
    localparam logic [7:0] OFS_ACMP = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;

    // Cause flag positions and value after power-up.
    localparam int BIT_PWRUP = 0;
    localparam int BIT_PIN = 1;
    localparam int BIT_DROP = 2;
    localparam int BIT_DOG = 3;
    localparam int BIT_SCAN = 4;
    localparam logic [4:0] CAUSE_RST = 5'h01;

    // Watchdog control fields.
    localparam int DC_CHG = 4;
    localparam int DC_EN = 3;
    localparam int DC_PER_LSB = 0;
    localparam int DC_PER_W = 3;
    localparam logic [2:0] CHG_WINDOW = 3'h4;

    // Status fields.
    localparam int ST_LVL_LSB = 0;
    localparam int ST_BGAP = 2;
    localparam int ST_DROP_EN = 3;
    localparam int ST_DROP_RSVD = 4;
    localparam int ST_CORE_RST = 5;

    // ****************************************
    // Safety levels and supply-drop level codes
    // ****************************************
    localparam logic [1:0] LVL_0 = 2'h0;
    localparam logic [1:0] LVL_1 = 2'h1;
    localparam logic [1:0] LVL_2 = 2'h2;
    localparam logic [2:0] DROP_OFF = 3'h7;
    localparam logic [2:0] DROP_LVL_A = 3'h5;
    localparam logic [2:0] DROP_LVL_B = 3'h4;
    localparam logic [2:0] DROP_LV_A = 3'h6;
    localparam logic [2:0] DROP_LV_B = 3'h3;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 10;
    localparam int PIN_MIN_NS = 2500;
    localparam int DROP_MIN_NS = 2000;
    localparam logic [7:0] PIN_MIN_CYC =
        8'((PIN_MIN_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] DROP_MIN_CYC =
        8'((DROP_MIN_NS * CLK_MHZ + 999) / 1000);
    localparam int DOG_OSC_KHZ = 1000;
    localparam int DOG_BASE_CYC = 16384;
    localparam int DOG_CNT_W = 22;
    localparam int BGAP_START_US = 70;

    typedef enum logic [1:0] {
        SEQ_HOLD,
        SEQ_COUNT,
        SEQ_RUN
    } rsw_seq_e;

endpackage

// ### rtl/rsw_dog_counter.sv
// Purpose: Watchdog period counter advanced by the watchdog oscillator.
// Assumes: dog_osc is synchronous to hclk and much slower than it.
// Notes:   expire is a one-cycle pulse; clear holds the count at zero.
module rsw_dog_counter #(
    parameter int DOG_BASE = rsw_pkg::DOG_BASE_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Control
    input wire logic dog_osc,
    input wire logic clear,
    input wire logic [2:0] dog_period_select,
    // Result
    output logic expire
);

    logic osc_q_r;
    logic expire_r;
    logic [rsw_pkg::DOG_CNT_W-1:0] cnt_r;
    logic [rsw_pkg::DOG_CNT_W-1:0] limit;
    logic tick;

    assign tick = dog_osc & ~osc_q_r;
    // Period doubles with each select code from the base count.
    assign limit = (rsw_pkg::DOG_CNT_W'(DOG_BASE) << dog_period_select)
        - 22'h000001;
    assign expire = expire_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_q_r <= 1'b0;
        end else if (ce) begin
            osc_q_r <= dog_osc;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= '0;
            expire_r <= 1'b0;
        end else if (ce) begin
            expire_r <= 1'b0;
            if (clear) begin
                cnt_r <= '0;
            end else if (tick) begin
                if (cnt_r >= limit) begin
                    cnt_r <= '0;
                    expire_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 22'h000001;
                end
            end
        end
    end

endmodule

// ### rtl/rsw_reset_source.sv
// Purpose: Reset sources, start-up delay, cause flags and watchdog control.
// Assumes: All inputs synchronous to hclk; hresetn is the power-on reset.
// Notes:   Registers are reached over AHB-Lite; wait states are inserted only while ce is low.
module rsw_reset_source #(
    parameter bit LOW_VOLT = 1'b0,
    parameter int DLY_W = 20,
    parameter int STARTUP_CYC_0 = 6,
    parameter int STARTUP_CYC_1 = 410,
    parameter int STARTUP_CYC_2 = 41000,
    parameter int STARTUP_CYC_3 = 655360,
    parameter int DOG_BASE = rsw_pkg::DOG_BASE_CYC
) (
    // Clock, reset and enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Reset sources
    input wire logic ext_reset_n,
    input wire logic supply_low,
    input wire logic scan_reset_instruction,
    // Configuration fuses, high when programmed
    input wire logic [2:0] supply_drop_level_cfg,
    input wire logic [1:0] clock_source_cfg,
    input wire logic legacy_compat_cfg,
    input wire logic dog_always_on_cfg,
    // Watchdog
    input wire logic dog_osc,
    input wire logic dog_restart_instr,
    // Outputs to the chip
    output logic core_reset,
    output logic supply_drop_enable,
    output logic bandgap_enable,
    output logic dog_reset_pulse
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [4:0] reset_cause_flags_r;
    logic [4:0] cause_set;
    logic [7:0] pin_cnt_r;
    logic [7:0] drop_cnt_r;
    logic pin_rst;
    logic drop_rst;
    logic drop_rsvd;
    logic src_any;
    rsw_pkg::rsw_seq_e seq_r;
    logic [DLY_W-1:0] dly_r;
    logic [DLY_W-1:0] dly_sel;
    logic [1:0] dog_level;
    logic dog_en_r;
    logic dog_chg_r;
    logic [2:0] chg_cnt_r;
    logic [2:0] dog_per_r;
    logic dog_en;
    logic comparator_ref_select_r;
    logic ap_valid_r;
    logic ap_write_r;
    logic [7:0] ap_addr_r;
    logic [31:0] hrdata_r;
    logic [31:0] rd_mux;
    logic take;
    logic wr_cause;
    logic wr_dog;
    logic wr_acmp;
    logic dog_expire;

    // ****************************************
    // Reset source qualification
    // ****************************************
    // A digital filter stands in for the analog minimum-width check; a
    // pin pulse while hclk is stopped is outside what this logic can see.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_cnt_r <= 8'h00;
        end else if (ce) begin
            if (ext_reset_n) begin
                pin_cnt_r <= 8'h00;
            end else if (pin_cnt_r != rsw_pkg::PIN_MIN_CYC) begin
                pin_cnt_r <= pin_cnt_r + 8'h01;
            end
        end
    end
    assign pin_rst = ~ext_reset_n
        & (pin_cnt_r == rsw_pkg::PIN_MIN_CYC);

    always_comb begin
        supply_drop_enable = 1'b0;
        drop_rsvd = 1'b0;
        case (supply_drop_level_cfg)
            rsw_pkg::DROP_OFF: supply_drop_enable = 1'b0;
            rsw_pkg::DROP_LVL_A,
            rsw_pkg::DROP_LVL_B: supply_drop_enable = 1'b1;
            rsw_pkg::DROP_LV_A,
            rsw_pkg::DROP_LV_B: begin
                supply_drop_enable = LOW_VOLT;
                drop_rsvd = ~LOW_VOLT;
            end
            default: drop_rsvd = 1'b1;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drop_cnt_r <= 8'h00;
        end else if (ce) begin
            if (!(supply_low && supply_drop_enable)) begin
                drop_cnt_r <= 8'h00;
            end else if (drop_cnt_r != rsw_pkg::DROP_MIN_CYC) begin
                drop_cnt_r <= drop_cnt_r + 8'h01;
            end
        end
    end
    assign drop_rst = supply_low & supply_drop_enable
        & (drop_cnt_r == rsw_pkg::DROP_MIN_CYC);

    assign dog_reset_pulse = dog_expire;
    assign src_any = pin_rst | drop_rst | dog_expire
        | scan_reset_instruction;

    // ****************************************
    // Start-up delay sequencer
    // ****************************************
    always_comb begin
        case (clock_source_cfg)
            2'h0: dly_sel = DLY_W'(STARTUP_CYC_0);
            2'h1: dly_sel = DLY_W'(STARTUP_CYC_1);
            2'h2: dly_sel = DLY_W'(STARTUP_CYC_2);
            default: dly_sel = DLY_W'(STARTUP_CYC_3);
        endcase
    end

    // Any active source sends the sequencer back to hold, so the delay is
    // always measured from the last source to go inactive.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_r <= rsw_pkg::SEQ_HOLD;
            dly_r <= '0;
        end else if (ce) begin
            case (seq_r)
                rsw_pkg::SEQ_HOLD: begin
                    if (!src_any) begin
                        seq_r <= rsw_pkg::SEQ_COUNT;
                        dly_r <= dly_sel;
                    end
                end
                rsw_pkg::SEQ_COUNT: begin
                    if (src_any) begin
                        seq_r <= rsw_pkg::SEQ_HOLD;
                    end else if (dly_r <= DLY_W'(1)) begin
                        seq_r <= rsw_pkg::SEQ_RUN;
                    end else begin
                        dly_r <= dly_r - DLY_W'(1);
                    end
                end
                rsw_pkg::SEQ_RUN: begin
                    if (src_any) begin
                        seq_r <= rsw_pkg::SEQ_HOLD;
                    end
                end
                default: seq_r <= rsw_pkg::SEQ_HOLD;
            endcase
        end
    end
    assign core_reset = src_any | (seq_r != rsw_pkg::SEQ_RUN);

    // ****************************************
    // Reset cause flags
    // ****************************************
    always_comb begin
        cause_set = 5'h00;
        cause_set[rsw_pkg::BIT_SCAN] = scan_reset_instruction;
        cause_set[rsw_pkg::BIT_DOG] = dog_expire;
        cause_set[rsw_pkg::BIT_DROP] = drop_rst;
        cause_set[rsw_pkg::BIT_PIN] = pin_rst;
    end

    // Writing one leaves a flag alone; a new cause beats a clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reset_cause_flags_r <= rsw_pkg::CAUSE_RST;
        end else if (ce) begin
            if (wr_cause) begin
                reset_cause_flags_r <= (reset_cause_flags_r & hwdata[4:0])
                    | cause_set;
            end else begin
                reset_cause_flags_r <= reset_cause_flags_r | cause_set;
            end
        end
    end

    // ****************************************
    // Reference enable and comparator select
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            comparator_ref_select_r <= 1'b0;
        end else if (ce) begin
            if (core_reset) begin
                comparator_ref_select_r <= 1'b0;
            end else if (wr_acmp) begin
                comparator_ref_select_r <= hwdata[0];
            end
        end
    end
    assign bandgap_enable = supply_drop_enable
        | comparator_ref_select_r;

    // ****************************************
    // Watchdog control
    // ****************************************
    always_comb begin
        if (dog_always_on_cfg) begin
            dog_level = rsw_pkg::LVL_2;
        end else if (legacy_compat_cfg) begin
            dog_level = rsw_pkg::LVL_0;
        end else begin
            dog_level = rsw_pkg::LVL_1;
        end
    end
    assign dog_en = dog_en_r | (dog_level == rsw_pkg::LVL_2);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dog_chg_r <= 1'b0;
            chg_cnt_r <= 3'h0;
        end else if (ce) begin
            if (core_reset) begin
                dog_chg_r <= 1'b0;
                chg_cnt_r <= 3'h0;
            end else if (wr_dog && hwdata[rsw_pkg::DC_CHG]
                    && hwdata[rsw_pkg::DC_EN]) begin
                dog_chg_r <= 1'b1;
                chg_cnt_r <= rsw_pkg::CHG_WINDOW;
            end else if (dog_chg_r) begin
                chg_cnt_r <= chg_cnt_r - 3'h1;
                if (chg_cnt_r == 3'h1) begin
                    dog_chg_r <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dog_en_r <= 1'b0;
            dog_per_r <= 3'h0;
        end else if (ce) begin
            if (core_reset) begin
                dog_en_r <= 1'b0;
                dog_per_r <= 3'h0;
            end else if (wr_dog) begin
                if (hwdata[rsw_pkg::DC_EN]) begin
                    dog_en_r <= 1'b1;
                end else if (dog_chg_r) begin
                    dog_en_r <= 1'b0;
                end
                if (dog_level == rsw_pkg::LVL_0 || dog_chg_r) begin
                    dog_per_r <= hwdata[rsw_pkg::DC_PER_LSB
                        +: rsw_pkg::DC_PER_W];
                end
            end
        end
    end

    rsw_dog_counter #(
        .DOG_BASE(DOG_BASE)
    ) u_dog (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .dog_osc(dog_osc),
        .clear(dog_restart_instr | ~dog_en | core_reset),
        .dog_period_select(dog_per_r),
        .expire(dog_expire)
    );

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    // Stalling the bus while ce is low keeps frozen state and bus in step.
    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign take = hsel & htrans[1] & hready & ce;
    assign wr_cause = ap_valid_r & ap_write_r
        & (ap_addr_r == rsw_pkg::OFS_CAUSE);
    assign wr_dog = ap_valid_r & ap_write_r
        & (ap_addr_r == rsw_pkg::OFS_DOGCTL);
    assign wr_acmp = ap_valid_r & ap_write_r
        & (ap_addr_r == rsw_pkg::OFS_ACMP);

    always_comb begin
        rd_mux = 32'h00000000;
        case (haddr[7:0])
            rsw_pkg::OFS_CAUSE: rd_mux[4:0] = reset_cause_flags_r;
            rsw_pkg::OFS_DOGCTL: begin
                rd_mux[rsw_pkg::DC_CHG] = dog_chg_r;
                rd_mux[rsw_pkg::DC_EN] = dog_en;
                rd_mux[rsw_pkg::DC_PER_LSB +: rsw_pkg::DC_PER_W] = dog_per_r;
            end
            rsw_pkg::OFS_ACMP: rd_mux[0] = comparator_ref_select_r;
            rsw_pkg::OFS_STATUS: begin
                rd_mux[rsw_pkg::ST_LVL_LSB +: 2] = dog_level;
                rd_mux[rsw_pkg::ST_BGAP] = bandgap_enable;
                rd_mux[rsw_pkg::ST_DROP_EN] = supply_drop_enable;
                rd_mux[rsw_pkg::ST_DROP_RSVD] = drop_rsvd;
                rd_mux[rsw_pkg::ST_CORE_RST] = core_reset;
            end
            default: rd_mux = 32'h00000000;
        endcase
        if (haddr[31:8] != 24'h000000) begin
            rd_mux = 32'h00000000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid_r <= 1'b0;
            ap_write_r <= 1'b0;
            ap_addr_r <= 8'h00;
            hrdata_r <= 32'h00000000;
        end else if (ce) begin
            ap_valid_r <= take & (haddr[31:8] == 24'h000000);
            ap_write_r <= hwrite;
            ap_addr_r <= haddr[7:0];
            if (take && !hwrite) begin
                hrdata_r <= rd_mux;
            end
        end
    end

endmodule

// ### tb/rsw_chk.sv
// Purpose: Port-level assertions for the reset source block.
// Assumes: One clock domain; hresetn low is the power-on reset.
// Notes:   Filter counters allow a few cycles for pin synchronising.
module rsw_chk #(
    parameter bit LOW_VOLT = 1'b0
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Sources and fuses
    input wire logic ext_reset_n,
    input wire logic supply_low,
    input wire logic scan_reset_instruction,
    input wire logic [2:0] supply_drop_level_cfg,
    // Outputs to the chip
    input wire logic core_reset,
    input wire logic supply_drop_enable,
    input wire logic bandgap_enable,
    input wire logic dog_reset_pulse
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [7:0] pin_cnt_r;
    logic [7:0] drop_cnt_r;
    logic drop_cfg;
    assign drop_cfg = supply_drop_level_cfg inside {3'h5, 3'h4} ||
        (LOW_VOLT && supply_drop_level_cfg inside {3'h6, 3'h3});
    // ****************************************
    // Consecutive low-pin and low-supply counts
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_cnt_r <= 8'h00;
        end else if (ext_reset_n) begin
            pin_cnt_r <= 8'h00;
        end else if (ce && pin_cnt_r != 8'hFF) begin
            pin_cnt_r <= pin_cnt_r + 8'h01;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drop_cnt_r <= 8'h00;
        end else if (!(supply_low && drop_cfg)) begin
            drop_cnt_r <= 8'h00;
        end else if (ce && drop_cnt_r != 8'hFF) begin
            drop_cnt_r <= drop_cnt_r + 8'h01;
        end
    end
    a_scan_now: assert property (scan_reset_instruction |-> core_reset)
        else $error("Scan request without core reset.");
    a_pin_reset: assert property (pin_cnt_r >= 8'h1C |-> core_reset)
        else $error("Long pin pulse without core reset.");
    a_drop_reset: assert property (drop_cnt_r >= 8'h17 |-> core_reset)
        else $error("Supply drop without core reset.");
    a_drop_decode: assert property (supply_drop_enable == drop_cfg)
        else $error("Supply-drop level code decoded wrongly.");
    a_bgap_follows: assert property (supply_drop_enable |-> bandgap_enable)
        else $error("Reference off while drop detection is on.");
    a_pulse_one: assert property (dog_reset_pulse |=> !dog_reset_pulse)
        else $error("Watchdog reset pulse longer than one cycle.");
    a_pulse_stretch: assert property ($fell(dog_reset_pulse) |->
        core_reset [*5])
        else $error("No start-up delay after watchdog pulse.");
    a_pin_stretch: assert property ($rose(ext_reset_n) &&
        pin_cnt_r >= 8'h1C |-> core_reset [*5])
        else $error("No start-up delay after pin release.");
    c_pin: cover property (pin_cnt_r == 8'h1C);
    c_dog: cover property (dog_reset_pulse);
    c_scan: cover property (scan_reset_instruction && core_reset);
endmodule

bind rsw_reset_source rsw_chk #(.LOW_VOLT(LOW_VOLT)) u_chk (
    .hclk, .hresetn, .ce, .ext_reset_n, .supply_low,
    .scan_reset_instruction, .supply_drop_level_cfg, .core_reset,
    .supply_drop_enable, .bandgap_enable, .dog_reset_pulse);

// ### tb/rsw_far_model.sv
// Purpose: Far side: reset pin, supply monitor, scan request, oscillator.
// Assumes: Bench commands change just after a rising hclk edge.
// Notes:   The oscillator runs free at a quarter of the hclk rate.
module rsw_far_model (
    // Commands from the bench
    input wire logic hclk,
    input wire logic pin_low,
    input wire logic drop,
    input wire logic scan,
    // Lines into the block
    output logic ext_reset_n,
    output logic supply_low,
    output logic scan_reset_instruction,
    output logic dog_osc = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic div_r = 1'b0;
    // The pin has a pull-up, so it idles high when nobody pulls it.
    assign ext_reset_n = ~pin_low;
    assign supply_low = drop;
    assign scan_reset_instruction = scan;
    // Kept synchronous to hclk because the block samples the level.
    always_ff @(posedge hclk) begin
        div_r <= ~div_r;
        if (div_r) begin
            dog_osc <= ~dog_osc;
        end
    end
endmodule

// ### tb/tb.sv
// Purpose: Self-checking bench for the reset source block.
// Assumes: AHB-Lite slave, zero-wait while ce is high; short start-up and watchdog counts.
// Notes:   Each scenario task drives the block and judges the result.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, core_reset, drop_en, bgap, dog_pulse;
    logic [31:0] hrdata;
    logic pin_low = 1'b0, drop = 1'b0, scan = 1'b0, restart = 1'b0;
    logic ext_reset_n, supply_low, scan_req, dog_osc;
    logic [2:0] lvl_cfg = 3'h7;
    logic legacy = 1'b0, always_on = 1'b0;
    logic ce_in = 1'b1;
    logic [1:0] clk_src = 2'h0;
    int num_errors = 0, cmp_count = 0, pulses = 0;
    always #50 hclk = ~hclk;
    always @(negedge hclk) begin
        if (dog_pulse === 1'b1) begin
            pulses++;
        end
    end
    rsw_far_model u_far (.hclk, .pin_low, .drop, .scan, .ext_reset_n,
        .supply_low, .scan_reset_instruction(scan_req), .dog_osc);
    rsw_reset_source #(.STARTUP_CYC_0(6), .STARTUP_CYC_1(8),
        .STARTUP_CYC_2(10), .STARTUP_CYC_3(12), .DOG_BASE(4)) u_dut (
        .hclk, .hresetn, .ce(ce_in), .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .ext_reset_n, .supply_low, .scan_reset_instruction(scan_req),
        .supply_drop_level_cfg(lvl_cfg), .clock_source_cfg(clk_src),
        .legacy_compat_cfg(legacy), .dog_always_on_cfg(always_on),
        .dog_osc, .dog_restart_instr(restart), .core_reset,
        .supply_drop_enable(drop_en), .bandgap_enable(bgap),
        .dog_reset_pulse(dog_pulse));
    // ****************************************
    // Bus, compare and wait helpers
    // ****************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
            input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask
    task automatic wait_run();
        int n;
        n = 0;
        while (core_reset !== 1'b0 && n < 200) begin
            @(posedge hclk);
            n++;
        end
        chk(core_reset, 1'b0);
    endtask
    task automatic stretch();
        repeat (3) @(posedge hclk);
        #1 chk(core_reset, 1'b1);
        wait_run();
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_pin();
        @(posedge hclk);
        pin_low <= 1'b1;
        repeat (30) @(posedge hclk);
        #1 chk(core_reset, 1'b1);
        @(posedge hclk);
        pin_low <= 1'b0;
        stretch();
        rd_chk(rsw_pkg::OFS_CAUSE, 32'hFF, 32'h03);
        wr(rsw_pkg::OFS_CAUSE, 32'h00);
        rd_chk(rsw_pkg::OFS_CAUSE, 32'hFF, 32'h00);
        @(posedge hclk);
        scan <= 1'b1;
        pin_low <= 1'b1;
        #1 chk(core_reset, 1'b1);
        repeat (30) @(posedge hclk);
        scan <= 1'b0;
        pin_low <= 1'b0;
        wait_run();
        rd_chk(rsw_pkg::OFS_CAUSE, 32'hFF, 32'h12);
        wr(rsw_pkg::OFS_CAUSE, 32'h00);
        $display("t_pin done");
    endtask
    task automatic t_drop();
        for (int c = 0; c < 8; c++) begin
            @(posedge hclk);
            lvl_cfg <= 3'(c);
            #1 chk(drop_en, c == 5 || c == 4);
            chk(bgap, c == 5 || c == 4);
        end
        wr(rsw_pkg::OFS_ACMP, 32'h01);
        #1 chk(bgap, 1'b1);
        repeat (rsw_pkg::BGAP_START_US * rsw_pkg::CLK_MHZ)
            @(posedge hclk);
        wr(rsw_pkg::OFS_ACMP, 32'h00);
        #1 chk(bgap, 1'b0);
        @(posedge hclk);
        lvl_cfg <= rsw_pkg::DROP_LVL_A;
        drop <= 1'b1;
        repeat (25) @(posedge hclk);
        #1 chk(core_reset, 1'b1);
        @(posedge hclk);
        drop <= 1'b0;
        stretch();
        rd_chk(rsw_pkg::OFS_CAUSE, 32'hFF, 32'h04);
        wr(rsw_pkg::OFS_CAUSE, 32'h00);
        $display("t_drop done");
    endtask
    task automatic t_ce();
        int n;
        @(posedge hclk);
        clk_src <= 2'h3;
        scan <= 1'b1;
        @(posedge hclk);
        scan <= 1'b0;
        ce_in <= 1'b0;
        repeat (20) @(posedge hclk);
        // A running sequencer would have left reset long before this.
        #1 chk(core_reset, 1'b1);
        chk(hreadyout, 1'b0);
        chk(hresp, 1'b0);
        @(posedge hclk);
        ce_in <= 1'b1;
        n = 0;
        do begin
            @(posedge hclk);
            #1 n++;
        end while (core_reset === 1'b1 && n < 50);
        // One hold edge plus the twelve cycles chosen by code 3.
        chk(n, 32'd13);
        rd_chk(rsw_pkg::OFS_CAUSE, 32'hFF, 32'h10);
        wr(rsw_pkg::OFS_CAUSE, 32'h00);
        $display("t_ce done");
    endtask
    task automatic t_dog();
        int n;
        int k;
        restart <= 1'b1;
        wr(rsw_pkg::OFS_DOGCTL, 32'h08);
        wr(rsw_pkg::OFS_DOGCTL, 32'h00);
        rd_chk(rsw_pkg::OFS_DOGCTL, 32'hFF, 32'h08);
        n = pulses;
        repeat (60) @(posedge hclk);
        chk(pulses, n);
        restart <= 1'b0;
        k = 0;
        while (pulses == n && k < 100) begin
            @(posedge hclk);
            k++;
        end
        chk(pulses, n + 1);
        #1 chk(core_reset, 1'b1);
        wait_run();
        rd_chk(rsw_pkg::OFS_CAUSE, 32'hFF, 32'h08);
        rd_chk(rsw_pkg::OFS_DOGCTL, 32'hFF, 32'h00);
        wr(rsw_pkg::OFS_DOGCTL, 32'h18);
        wr(rsw_pkg::OFS_DOGCTL, 32'h00);
        repeat (4) @(posedge hclk);
        rd_chk(rsw_pkg::OFS_DOGCTL, 32'hFF, 32'h00);
        n = pulses;
        repeat (80) @(posedge hclk);
        chk(pulses, n);
        $display("t_dog done");
    endtask
    task automatic t_lvl();
        logic [1:0] exp_lvl [4] = '{2'h1, 2'h2, 2'h0, 2'h2};
        for (int f = 0; f < 4; f++) begin
            @(posedge hclk);
            {legacy, always_on} <= 2'(f);
            rd_chk(rsw_pkg::OFS_STATUS, 32'h03, {30'h0, exp_lvl[f]});
        end
        rd_chk(rsw_pkg::OFS_DOGCTL, 32'h08, 32'h08);
        $display("t_lvl done");
    endtask
    task automatic conclude();
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        stretch();
        rd_chk(rsw_pkg::OFS_CAUSE, 32'hFF, 32'h01);
        t_pin();
        t_drop();
        t_ce();
        t_dog();
        t_lvl();
        conclude();
    end
    initial begin
        #2000000;
        num_errors++;
        conclude();
    end
endmodule
